//--- rtl/nvb_map.vh
// Register indices, field positions, reset values and timing of the
// nonvolatile byte controller. Definitions only; included by nvb_ctrl.
`ifndef NVB_MAP_VH
`define NVB_MAP_VH

// Register indices; byte address on the bus is four times the index
`define NVB_IDX_FLAG 8'h0c
`define NVB_IDX_BYTE 8'h9a
`define NVB_IDX_INDEX 8'h9b
`define NVB_IDX_CTRL 8'h9c
`define NVB_IDX_KEY 8'h9d

// Control register fields
`define NVB_CTRL_RD 0
`define NVB_CTRL_WR 1
`define NVB_CTRL_EN 2
`define NVB_CTRL_ABORT 3

// Peripheral flag register field
`define NVB_FLAG_DONE 7

// Reset values
`define NVB_RST_BYTE 8'h00
`define NVB_RST_INDEX 7'h00

// Unlock key values, in order
`define NVB_KEY_FIRST 8'h55
`define NVB_KEY_SECOND 8'haa

// Content of an erased location
`define NVB_ERASED 8'hff

// Array geometry
`define NVB_DEPTH 128
`define NVB_AW 7

// Write cycle time in microseconds and clock rate in MHz
`define NVB_WRITE_TIME_US 20'd5000
`define NVB_CLK_MHZ 20'd125
`define NVB_WRITE_CYCLES (`NVB_WRITE_TIME_US * `NVB_CLK_MHZ)

`endif

//--- rtl/nvb_mem.v
// Holds the 128-byte data array with one write and one read port.
// Assumes a single clock; read data come out of a register.
`timescale 1ns/10ps
module nvb_mem (
    input wire clk_sys_i,
    input wire we_i,
    input wire [6:0] waddr_i,
    input wire [7:0] wdata_i,
    input wire re_i,
    input wire [6:0] raddr_i,
    output reg [7:0] rdata_o
);

    reg [7:0] cell_reg [0:127];

    // Write port; no reset, the array keeps its content
    always @(posedge clk_sys_i) begin
        if (we_i) begin
            cell_reg[waddr_i] <= wdata_i;
        end
    end

    // Registered read; held until the next read
    always @(posedge clk_sys_i) begin
        if (re_i) begin
            rdata_o <= cell_reg[raddr_i];
        end
    end

endmodule // nvb_mem

//--- rtl/nvb_ctrl.v
// Access controller for a 128-byte nonvolatile data array behind
// byte, index, control, flag and unlock registers on Avalon-MM.
// Assumes one clock, a synchronous high reset, and abort sources
// arriving asynchronously from pins.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "nvb_map.vh"
module nvb_ctrl #(
    parameter [19:0] WRITE_CYCLES = `NVB_WRITE_CYCLES
) (
    input wire clk_sys_i,
    input wire srst_i,
    // Avalon-MM slave, byte address
    input wire [9:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [3:0] avs_byteenable_i,
    input wire [31:0] avs_writedata_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o,
    // Asynchronous abort sources and protection strap level
    input wire ext_reset_pin_i,
    input wire watchdog_timeout_i,
    input wire brownout_detect_i,
    input wire code_protect_i,
    // External programmer access, same clock
    input wire prog_rd_i,
    input wire prog_wr_i,
    input wire [6:0] prog_addr_i,
    input wire [7:0] prog_wdata_i,
    output reg [7:0] prog_rdata_o,
    output reg prog_ack_o,
    // Status
    output reg program_done_o,
    output reg busy_o
);

    localparam ST_IDLE = 3'b001;
    localparam ST_ERASE = 3'b010;
    localparam ST_PROG = 3'b100;
    localparam [19:0] ERASE_CYCLES = WRITE_CYCLES >> 1;
    localparam [19:0] PROG_CYCLES = WRITE_CYCLES - ERASE_CYCLES;
    localparam [1:0] KEY_NONE = 2'h0;
    localparam [1:0] KEY_HALF = 2'h1;
    localparam [1:0] KEY_ARMED = 2'h2;

    // Register index match
    function sel;
        input [7:0] idx;
        input [7:0] off;
        begin
            sel = (idx == off);
        end
    endfunction

    reg [7:0] nv_byte_reg;
    reg [6:0] nv_index_reg;
    reg rd_reg;
    reg wr_reg;
    reg en_reg;
    reg abort_reg;
    reg done_reg;
    reg [1:0] key_reg;
    reg [2:0] st_reg;
    reg [19:0] cnt_reg;
    reg [6:0] lat_index_reg;
    reg [7:0] lat_byte_reg;
    reg prog_pend_reg;
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;

    wire [7:0] mem_rdata;
    wire [7:0] bus_idx = avs_address_i[9:2];
    wire [7:0] wbyte = avs_writedata_i[7:0];
    wire bus_take = (avs_read_i | avs_write_i) & avs_waitrequest_o;
    wire wr_hit = bus_take & avs_write_i & avs_byteenable_i[0];
    wire abort_any = sync2_reg[0] | sync2_reg[1] | sync2_reg[2];
    wire protect = sync2_reg[3];
    wire idle = st_reg[0];
    wire erase_end = st_reg[1] & (cnt_reg == ERASE_CYCLES - 20'h1);
    wire prog_end = st_reg[2] & (cnt_reg == PROG_CYCLES - 20'h1);
    wire ctrl_wr = wr_hit & sel(bus_idx, `NVB_IDX_CTRL) & ~abort_any;
    wire key_wr = wr_hit & sel(bus_idx, `NVB_IDX_KEY) & ~abort_any;

    // Read start: only a one takes effect, never while pending
    wire rd_go = ctrl_wr & wbyte[`NVB_CTRL_RD] & ~rd_reg;
    // Program start needs enable, armed key and an idle engine
    wire wr_go = ctrl_wr & wbyte[`NVB_CTRL_WR] & en_reg & ~wr_reg & idle & (key_reg == KEY_ARMED);
    // Programmer waits for an idle engine and a free read port
    wire prog_go = (prog_rd_i | prog_wr_i) & ~prog_pend_reg & ~prog_ack_o & idle & ~rd_go & ~wr_go & ~abort_any;
    // Programmer writes are dropped under protection
    wire prog_we = prog_go & prog_wr_i & ~protect;

    // Array write port: erase pattern, then latched byte
    wire mem_we = erase_end | prog_end | prog_we;
    wire [6:0] mem_waddr = prog_we ? prog_addr_i : lat_index_reg;
    wire [7:0] mem_wdata = prog_we ? prog_wdata_i : (erase_end ? `NVB_ERASED : lat_byte_reg);
    // Array read port; index bit 7 is never stored, so never decoded
    wire mem_re = rd_go | prog_go;
    wire [6:0] mem_raddr = rd_go ? nv_index_reg : prog_addr_i;

    nvb_mem u_mem (
        .clk_sys_i(clk_sys_i),
        .we_i(mem_we),
        .waddr_i(mem_waddr),
        .wdata_i(mem_wdata),
        .re_i(mem_re),
        .raddr_i(mem_raddr),
        .rdata_o(mem_rdata)
    );

    // Two-stage synchronisers for the pin-level inputs
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {code_protect_i, brownout_detect_i, watchdog_timeout_i, ext_reset_pin_i};
            sync2_reg <= sync1_reg;
        end
    end

    // Bus handshake: one wait cycle, then a single low waitrequest
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0;
        end else if (bus_take) begin
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= 32'h0;
            if (avs_read_i) begin
                // Unlock port and unmapped indices read zero
                if (sel(bus_idx, `NVB_IDX_BYTE)) begin
                    avs_readdata_o <= {24'h0, nv_byte_reg};
                end else if (sel(bus_idx, `NVB_IDX_INDEX)) begin
                    avs_readdata_o <= {25'h0, nv_index_reg};
                end else if (sel(bus_idx, `NVB_IDX_CTRL)) begin
                    // Upper nibble unimplemented
                    avs_readdata_o <= {28'h0, abort_reg, en_reg, wr_reg, rd_reg};
                end else if (sel(bus_idx, `NVB_IDX_FLAG)) begin
                    avs_readdata_o <= {24'h0, done_reg, 7'h0};
                end
            end
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    // Unlock sequence tracker; any other write breaks it
    always @(posedge clk_sys_i) begin
        if (srst_i || abort_any) begin
            key_reg <= KEY_NONE;
        end else if (key_wr) begin
            if (wbyte == `NVB_KEY_FIRST) begin
                key_reg <= KEY_HALF;
            end else if (wbyte == `NVB_KEY_SECOND && key_reg == KEY_HALF) begin
                key_reg <= KEY_ARMED;
            end else begin
                key_reg <= KEY_NONE;
            end
        end else if (wr_hit) begin
            // Also consumed by the control write itself, good or not
            key_reg <= KEY_NONE;
        end
    end

    // Write engine: erase half, program half, timed here
    always @(posedge clk_sys_i) begin
        if (srst_i || abort_any) begin
            st_reg <= ST_IDLE;
            cnt_reg <= 20'h0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    cnt_reg <= 20'h0;
                    if (wr_go) begin
                        st_reg <= ST_ERASE;
                    end
                end
                ST_ERASE: begin
                    if (erase_end) begin
                        st_reg <= ST_PROG;
                        cnt_reg <= 20'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 20'h1;
                    end
                end
                ST_PROG: begin
                    // Enable is not looked at here
                    if (prog_end) begin
                        st_reg <= ST_IDLE;
                        cnt_reg <= 20'h0;
                    end else begin
                        cnt_reg <= cnt_reg + 20'h1;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                    cnt_reg <= 20'h0;
                end
            endcase
        end
    end

    // Latch target at start so later register writes cannot corrupt it
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            lat_index_reg <= `NVB_RST_INDEX;
            lat_byte_reg <= `NVB_RST_BYTE;
        end else if (wr_go) begin
            lat_index_reg <= nv_index_reg;
            lat_byte_reg <= nv_byte_reg;
        end
    end

    // Byte and index registers
    always @(posedge clk_sys_i) begin
        if (srst_i || abort_any) begin
            // Cleared by any reset, so an aborted write must reload both
            nv_byte_reg <= `NVB_RST_BYTE;
            nv_index_reg <= `NVB_RST_INDEX;
        end else begin
            if (rd_reg) begin
                // Fetched byte lands one cycle after the start
                nv_byte_reg <= mem_rdata;
            end else if (wr_hit && sel(bus_idx, `NVB_IDX_BYTE)) begin
                nv_byte_reg <= wbyte;
            end
            if (wr_hit && sel(bus_idx, `NVB_IDX_INDEX)) begin
                nv_index_reg <= wbyte[6:0];
            end
        end
    end

    // Control bits
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            en_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else if (abort_any) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            en_reg <= 1'b0;
            if (!idle) begin
                abort_reg <= 1'b1;
            end
        end else begin
            // Read start lives one cycle only
            rd_reg <= rd_go;
            // Software can only set; hardware clears at the end
            if (wr_go) begin
                wr_reg <= 1'b1;
            end else if (prog_end) begin
                wr_reg <= 1'b0;
            end
            if (ctrl_wr) begin
                en_reg <= wbyte[`NVB_CTRL_EN];
            end
            // Completion wins over a software write of the same cycle
            if (prog_end) begin
                abort_reg <= 1'b0;
            end else if (ctrl_wr) begin
                abort_reg <= wbyte[`NVB_CTRL_ABORT];
            end
        end
    end

    // Done flag: hardware set wins over a same-cycle software clear
    always @(posedge clk_sys_i) begin
        if (srst_i || abort_any) begin
            done_reg <= 1'b0;
        end else if (prog_end) begin
            done_reg <= 1'b1;
        end else if (wr_hit && sel(bus_idx, `NVB_IDX_FLAG)) begin
            done_reg <= wbyte[`NVB_FLAG_DONE];
        end
    end

    // Programmer port: ack two edges after acceptance, zeros if protected
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            prog_pend_reg <= 1'b0;
            prog_ack_o <= 1'b0;
            prog_rdata_o <= 8'h00;
        end else begin
            prog_pend_reg <= prog_go;
            prog_ack_o <= prog_pend_reg;
            if (prog_pend_reg) begin
                prog_rdata_o <= protect ? 8'h00 : mem_rdata;
            end
        end
    end

    // Status outputs, registered copies
    always @(posedge clk_sys_i) begin
        if (srst_i) begin
            program_done_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            program_done_o <= done_reg;
            busy_o <= ~idle;
        end
    end

endmodule // nvb_ctrl

//--- dv/nvb_ctrl_properties.sv
// Port-level checks for the nonvolatile byte controller.
// Assumes a bind to nvb_ctrl; one clock, synchronous high reset.
`timescale 1ns/10ps
`include "nvb_map.vh"
module nvb_ctrl_properties #(
    parameter [19:0] WRITE_CYCLES = 20
) (
    input wire clk_sys_i,
    input wire srst_i,
    input wire [9:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire avs_waitrequest_o,
    input wire code_protect_i,
    input wire prog_ack_o,
    input wire [7:0] prog_rdata_o,
    input wire busy_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    reg [19:0] busy_cnt_reg;
    wire taken = (avs_read_i || avs_write_i) && avs_waitrequest_o;
    wire rd_taken = avs_read_i && avs_waitrequest_o;
    // Length of the running write; a stuck engine would overrun the timer
    always @(posedge clk_sys_i) begin
        if (srst_i || !busy_o) begin
            busy_cnt_reg <= 20'h00000;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 20'h00001;
        end
    end
    a_wait_answer: assert property (taken |=> !avs_waitrequest_o) else $error("no answer after request");
    a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer too long");
    a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000) else $error("upper read lanes set");
    a_key_zero: assert property (rd_taken && avs_address_i[9:2] == `NVB_IDX_KEY |=>
        avs_readdata_o == 32'h00000000) else $error("unlock port read not zero");
    a_ctrl_upper: assert property (rd_taken && avs_address_i[9:2] == `NVB_IDX_CTRL |=>
        avs_readdata_o[7:4] == 4'h0) else $error("control upper bits set");
    a_index_msb: assert property (rd_taken && avs_address_i[9:2] == `NVB_IDX_INDEX |=>
        !avs_readdata_o[7]) else $error("index top bit set");
    a_ack_pulse: assert property (prog_ack_o |=> !prog_ack_o) else $error("programmer ack too long");
    a_prog_blocked: assert property (prog_ack_o && code_protect_i && $past(code_protect_i, 4) |->
        prog_rdata_o == 8'h00) else $error("protected data leaked");
    a_busy_hold: assert property ($rose(busy_o) |-> busy_o [*8]) else $error("write cut short");
    a_busy_bound: assert property (busy_cnt_reg <= WRITE_CYCLES) else $error("write overran");
    c_write_done: cover property ($fell(busy_o));
    c_prog_prot: cover property (prog_ack_o && code_protect_i);
    c_key_read: cover property (rd_taken && avs_address_i[9:2] == `NVB_IDX_KEY);
endmodule // nvb_ctrl_properties

//--- dv/test_nvb_ctrl.sv
// Self-checking bench for the nonvolatile byte controller.
// Assumes nvb_ctrl with a short write timer; bus reads checked via a queue.
`timescale 1ns/10ps
`include "nvb_map.vh"
module test_nvb_ctrl;
    localparam [19:0] WRITE_CYCLES = 20'd20;
    reg clk_sys_i = 1'b0;
    reg srst_i = 1'b1;
    reg [9:0] avs_address_i = 10'h000;
    reg avs_read_i = 1'b0;
    reg avs_write_i = 1'b0;
    reg [31:0] avs_writedata_i = 32'h0;
    wire [31:0] avs_readdata_o;
    wire avs_waitrequest_o;
    reg ext_reset_pin_i = 1'b0;
    reg watchdog_timeout_i = 1'b0;
    reg brownout_detect_i = 1'b0;
    reg code_protect_i = 1'b0;
    reg prog_rd_i = 1'b0;
    reg prog_wr_i = 1'b0;
    reg [6:0] prog_addr_i = 7'h00;
    reg [7:0] prog_wdata_i = 8'h00;
    wire [7:0] prog_rdata_o;
    wire prog_ack_o;
    wire program_done_o;
    wire busy_o;
    integer n_fail = 0;
    integer comparisons = 0;
    integer i;
    logic [7:0] a, d, d2;
    logic [31:0] bus_q[$];
    logic [7:0] prog_q[$];

    nvb_ctrl #(.WRITE_CYCLES(WRITE_CYCLES)) uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(4'h1), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .ext_reset_pin_i(ext_reset_pin_i),
        .watchdog_timeout_i(watchdog_timeout_i), .brownout_detect_i(brownout_detect_i),
        .code_protect_i(code_protect_i), .prog_rd_i(prog_rd_i), .prog_wr_i(prog_wr_i),
        .prog_addr_i(prog_addr_i), .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o),
        .prog_ack_o(prog_ack_o), .program_done_o(program_done_o), .busy_o(busy_o));

    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Oldest note is matched against each answer as it appears
    always @(posedge clk_sys_i) begin
        if (avs_read_i && avs_waitrequest_o === 1'b0) chk(avs_readdata_o, bus_q.pop_front());
        if (prog_rd_i && prog_ack_o === 1'b1) chk({24'h0, prog_rdata_o}, {24'h0, prog_q.pop_front()});
    end

    // Request held until waitrequest is seen low, giving up after 50 cycles
    task bus(input logic w, input logic [7:0] idx, input logic [7:0] dat);
        integer n;
        @(posedge clk_sys_i);
        avs_address_i <= {idx, 2'b00};
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h000000, dat};
        n = 0;
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0 && n < 50) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (n == 50) n_fail++;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] dat);
        bus(1'b1, idx, dat);
    endtask

    task rd(input logic [7:0] idx, input logic [7:0] exp);
        bus_q.push_back({24'h000000, exp});
        bus(1'b0, idx, 8'h00);
    endtask

    task wbyte(input logic [7:0] idx, input logic [7:0] dat);
        wr(`NVB_IDX_INDEX, idx);
        wr(`NVB_IDX_BYTE, dat);
        wr(`NVB_IDX_CTRL, 8'h04);
        wr(`NVB_IDX_KEY, `NVB_KEY_FIRST);
        wr(`NVB_IDX_KEY, `NVB_KEY_SECOND);
        wr(`NVB_IDX_CTRL, 8'h06);
    endtask

    task rdarr(input logic [7:0] idx, input logic [7:0] exp);
        wr(`NVB_IDX_INDEX, idx);
        wr(`NVB_IDX_CTRL, 8'h01);
        rd(`NVB_IDX_BYTE, exp);
    endtask

    task wait_done;
        integer n;
        n = 0;
        while (program_done_o !== 1'b1 && n < 200) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (n == 200) n_fail++;
    endtask

    task prog(input logic w, input logic [6:0] ad, input logic [7:0] dat, input logic [7:0] exp);
        integer n;
        if (!w) prog_q.push_back(exp);
        @(posedge clk_sys_i);
        prog_rd_i <= !w;
        prog_wr_i <= w;
        prog_addr_i <= ad;
        prog_wdata_i <= dat;
        n = 0;
        @(posedge clk_sys_i);
        while (prog_ack_o !== 1'b1 && n < 100) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (n == 100) n_fail++;
        prog_rd_i <= 1'b0;
        prog_wr_i <= 1'b0;
    endtask

    task finish_test;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard; a full run takes several hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        finish_test;
    end

    initial begin
        d = $urandom(42691);
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rd(`NVB_IDX_BYTE, 8'h00);
        rd(`NVB_IDX_INDEX, 8'h00);
        rd(`NVB_IDX_CTRL, 8'h00);
        rd(`NVB_IDX_FLAG, 8'h00);
        rd(8'h40, 8'h00);
        wr(`NVB_IDX_CTRL, 8'hf0);
        rd(`NVB_IDX_CTRL, 8'h00);
        wr(`NVB_IDX_KEY, 8'h5a);
        rd(`NVB_IDX_KEY, 8'h00);
        wr(`NVB_IDX_INDEX, 8'hff);
        rd(`NVB_IDX_INDEX, 8'h7f);
        // Random bytes, first at the top location, read back through the alias
        for (i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'h7f : $urandom;
            d = $urandom;
            wbyte(a, d);
            wait_done;
            rd(`NVB_IDX_FLAG, 8'h80);
            rd(`NVB_IDX_CTRL, 8'h04);
            wr(`NVB_IDX_FLAG, 8'h00);
            rd(`NVB_IDX_FLAG, 8'h00);
            rdarr(a ^ 8'h80, d);
            rd(`NVB_IDX_CTRL, 8'h00);
        end
        // Correct keys but no enable: start must be refused
        wr(`NVB_IDX_BYTE, ~d);
        wr(`NVB_IDX_KEY, `NVB_KEY_FIRST);
        wr(`NVB_IDX_KEY, `NVB_KEY_SECOND);
        wr(`NVB_IDX_CTRL, 8'h02);
        rd(`NVB_IDX_CTRL, 8'h00);
        repeat (30) @(posedge clk_sys_i);
        rdarr(a, d);
        // Keys in the wrong order
        wr(`NVB_IDX_BYTE, ~d);
        wr(`NVB_IDX_CTRL, 8'h04);
        wr(`NVB_IDX_KEY, `NVB_KEY_SECOND);
        wr(`NVB_IDX_KEY, `NVB_KEY_FIRST);
        wr(`NVB_IDX_CTRL, 8'h06);
        rd(`NVB_IDX_CTRL, 8'h04);
        rdarr(a, d);
        // Enable dropped and registers changed while the write runs
        d2 = $urandom;
        wbyte(a, d2);
        wr(`NVB_IDX_CTRL, 8'h00);
        wr(`NVB_IDX_BYTE, ~d2);
        rd(`NVB_IDX_CTRL, 8'h02);
        wait_done;
        wr(`NVB_IDX_FLAG, 8'h00);
        rdarr(a, d2);
        prog(1'b0, a[6:0], 8'h00, d2);
        code_protect_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        prog(1'b1, a[6:0], ~d2, 8'h00);
        prog(1'b0, a[6:0], 8'h00, 8'h00);
        rdarr(a, d2);
        code_protect_i <= 1'b0;
        // Each abort source cuts a running write
        for (i = 0; i < 3; i++) begin
            wbyte(a, d);
            repeat (10) @(posedge clk_sys_i);
            {ext_reset_pin_i, watchdog_timeout_i, brownout_detect_i} <= 3'b100 >> i;
            repeat (4) @(posedge clk_sys_i);
            {ext_reset_pin_i, watchdog_timeout_i, brownout_detect_i} <= 3'b000;
            repeat (4) @(posedge clk_sys_i);
            rd(`NVB_IDX_CTRL, 8'h08);
            rd(`NVB_IDX_BYTE, 8'h00);
            rd(`NVB_IDX_INDEX, 8'h00);
            if (i < 2) begin
                wr(`NVB_IDX_CTRL, 8'h00);
                rd(`NVB_IDX_CTRL, 8'h00);
            end
        end
        // A completed write clears the left-over abort flag; abort bit kept set until then
        wr(`NVB_IDX_INDEX, a);
        wr(`NVB_IDX_BYTE, d);
        wr(`NVB_IDX_CTRL, 8'h0c);
        wr(`NVB_IDX_KEY, `NVB_KEY_FIRST);
        wr(`NVB_IDX_KEY, `NVB_KEY_SECOND);
        wr(`NVB_IDX_CTRL, 8'h0e);
        rd(`NVB_IDX_CTRL, 8'h0e);
        wait_done;
        rd(`NVB_IDX_CTRL, 8'h04);
        rdarr(a, d);
        finish_test;
    end
endmodule // test_nvb_ctrl

bind nvb_ctrl nvb_ctrl_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (.clk_sys_i(clk_sys_i),
    .srst_i(srst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .code_protect_i(code_protect_i),
    .prog_ack_o(prog_ack_o), .prog_rdata_o(prog_rdata_o), .busy_o(busy_o));
